// ---- dtp_host_port.v ----
// Purpose: Host port, alert output, burst timer and power control.
// Assumes: All host pins are sampled on the core clock.
// Notes: Open-drain and two-way pins appear as separate in/out/enable.
`timescale 1ns/1ps
`include "dtp_defs.vh"
`default_nettype none
module dtp_host_port #(
    parameter CNT_W = 22, // Width of the burst counter.
    parameter BURST_CYC = `DTP_BURST_MS * `DTP_CLK_KHZ, // Tone burst cycles.
    parameter PAUSE_CYC = `DTP_PAUSE_MS * `DTP_CLK_KHZ // Pause cycles.
) (
    input wire i_clk, // Core clock, 40 MHz.
    input wire i_rst, // Asynchronous reset, active high.
    input wire i_bus_style, // 0 strobe with direction, 1 separate strobes.
    input wire i_chip_sel_n, // Chip select, active low.
    input wire i_rw_or_wr_n, // Direction select or write strobe.
    input wire i_data_strobe_in, // Data strobe or read strobe.
    input wire i_reg_select_line, // Register select.
    input wire [3:0] i_host_data_lines, // Data lines as seen on the pins.
    output reg [3:0] o_host_data_lines, // Data lines driven value.
    output reg o_host_data_lines_oe, // Data lines drive enable.
    input wire i_rx_power_down, // Receiver power down.
    input wire i_tx_power_down, // Transmitter power down.
    input wire i_tone_valid, // Detector sees a valid pair.
    input wire [1:0] i_low_idx, // Detected low group index.
    input wire [1:0] i_high_idx, // Detected high group index.
    input wire i_cp_limited, // Limited call-progress band signal.
    input wire i_steering_pin, // Steering level above threshold.
    output wire o_early_tone_detect, // Early detect output.
    output wire o_guard_drive, // Guard drive value.
    output wire o_guard_drive_oe, // Guard drive enable.
    output reg o_alert_or_tone_monitor, // Alert pin driven value.
    output reg o_alert_or_tone_monitor_oe, // Alert pin pull-down enable.
    output reg o_tone_on, // Tone synthesizer running.
    output reg [3:0] o_tone_code, // Code being synthesized.
    output reg o_tone_oe, // Tone output pin enabled.
    output reg o_cp_filter_sel, // Call-progress filter selected.
    output reg o_osc_enable // Oscillator and reference enable.
);
    // Burst sequencer states.
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_TONE = 2'b01;
    localparam [1:0] ST_PAUSE = 2'b10;
    localparam integer BURST_M1 = BURST_CYC - 1; // Full width.
    localparam integer PAUSE_M1 = PAUSE_CYC - 1; // Full width.
    localparam [CNT_W-1:0] BURST_LAST = BURST_M1[CNT_W-1:0]; // Cut to the counter.
    localparam [CNT_W-1:0] PAUSE_LAST = PAUSE_M1[CNT_W-1:0]; // Cut to the counter.

    wire both_pd; // Both halves asleep.
    wire rd_act; // A read is presently selected.
    wire wr_act; // A write is presently selected.
    wire wr_end; // Write strobe just ended.
    wire rd_end; // Read strobe just ended.
    wire [3:0] dec_code; // Decoded tone pair.
    wire [3:0] rx_code; // Receive output latch.
    wire dsf; // Delayed steering flag.
    reg wr_act_r; // Write active last cycle.
    reg rd_act_r; // Read active last cycle.
    reg rd_rs_r; // Register selected during the read.
    reg wr_rs_r; // Register selected during the write.
    reg [3:0] wr_data_r; // Data captured during the write.
    reg [3:0] ctrl_r; // Control register.
    reg [3:0] tx_data_r; // Transmit data register.
    reg tx_empty_r; // Transmit register free.
    reg tx_flag_r; // Burst-done event pending.
    reg rx_flag_r; // Received-pair event pending.
    reg dsf_r; // Delayed flag last cycle.
    reg [1:0] state_r; // Burst sequencer state.
    reg [1:0] state_nxt; // Next sequencer state.
    reg [CNT_W-1:0] cnt_r; // Burst sequencer counter.
    reg [CNT_W-1:0] cnt_nxt; // Next counter value.
    reg burst_done; // Pause just finished.
    reg [3:0] rd_mux; // Selected read data.
    reg alert_pull; // Alert pin wants to pull low.

    // Oscillator and shared circuits stop only with both halves asleep.
    assign both_pd = i_rx_power_down & i_tx_power_down;

    // Access decode. The host has qualified chip select with its own
    // address strobe, and only moves the strobe while accessing.
    assign rd_act = !i_chip_sel_n & (i_bus_style ? !i_data_strobe_in :
        (i_data_strobe_in & i_rw_or_wr_n));
    assign wr_act = !i_chip_sel_n & (i_bus_style ? !i_rw_or_wr_n :
        (i_data_strobe_in & !i_rw_or_wr_n));
    assign wr_end = wr_act_r & !wr_act;
    assign rd_end = rd_act_r & !rd_act;

    // Tone pair lookup.
    dtp_tone_decode u_decode (
        .i_low_idx(i_low_idx),
        .i_high_idx(i_high_idx),
        .o_code(dec_code)
    );

    // Steering and early detect.
    dtp_steer u_steer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_tone_valid(i_tone_valid),
        .i_code(dec_code),
        .i_steering_pin(i_steering_pin),
        .i_rx_pd(i_rx_power_down),
        .o_early_tone_detect(o_early_tone_detect),
        .o_guard_drive(o_guard_drive),
        .o_guard_drive_oe(o_guard_drive_oe),
        .o_rx_code(rx_code),
        .o_delayed_steer(dsf)
    );

    // Capture write data and register select while the strobe is held,
    // so the value committed is the one standing just before release.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_act_r <= 1'b0;
            rd_act_r <= 1'b0;
            wr_rs_r <= 1'b0;
            rd_rs_r <= 1'b0;
            wr_data_r <= 4'h0;
        end else begin
            wr_act_r <= wr_act;
            rd_act_r <= rd_act;
            if (wr_act) begin
                wr_rs_r <= i_reg_select_line;
                wr_data_r <= i_host_data_lines;
            end
            if (rd_act) begin
                rd_rs_r <= i_reg_select_line;
            end
        end
    end

    // Read data selection: receive latch or status.
    always @* begin
        if (i_reg_select_line == `DTP_RS_CTRL) begin
            rd_mux = 4'h0;
            rd_mux[`DTP_STAT_IRQ] = rx_flag_r | tx_flag_r;
            rd_mux[`DTP_STAT_TX_EMPTY] = tx_empty_r;
            rd_mux[`DTP_STAT_RX_READY] = dsf;
        end else begin
            rd_mux = rx_code;
        end
    end

    // Data lines drive only during a selected read; floated otherwise
    // and whenever both halves are powered down.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_host_data_lines <= 4'h0;
            o_host_data_lines_oe <= 1'b0;
        end else begin
            o_host_data_lines <= rd_mux;
            o_host_data_lines_oe <= rd_act & !both_pd;
        end
    end

    // Burst sequencer next state: tone for a fixed time, then pause.
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        burst_done = 1'b0;
        case (state_r)
            ST_IDLE: begin
                // A write to the data register starts a timed burst.
                if (wr_end && wr_rs_r == `DTP_RS_DATA && ctrl_r[`DTP_CTRL_BURST]
                    && !i_tx_power_down) begin
                    state_nxt = ST_TONE;
                    cnt_nxt = BURST_LAST;
                end
            end
            ST_TONE: begin
                if (cnt_r == {CNT_W{1'b0}}) begin
                    state_nxt = ST_PAUSE;
                    cnt_nxt = PAUSE_LAST;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_PAUSE: begin
                if (cnt_r == {CNT_W{1'b0}}) begin
                    state_nxt = ST_IDLE;
                    burst_done = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Powering the transmitter down abandons any burst.
        if (i_tx_power_down) begin
            state_nxt = ST_IDLE;
            cnt_nxt = {CNT_W{1'b0}};
            burst_done = 1'b0;
        end
    end

    // Control and transmit registers, sequencer and event flags.
    // An event in the cycle of a status read survives the clear.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r <= `DTP_CTRL_RST;
            tx_data_r <= 4'h0;
            tx_empty_r <= 1'b1;
            tx_flag_r <= 1'b0;
            rx_flag_r <= 1'b0;
            dsf_r <= 1'b0;
            state_r <= ST_IDLE;
            cnt_r <= {CNT_W{1'b0}};
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            dsf_r <= dsf;
            if (wr_end && wr_rs_r == `DTP_RS_CTRL) begin
                ctrl_r <= wr_data_r;
            end
            if (wr_end && wr_rs_r == `DTP_RS_DATA) begin
                tx_data_r <= wr_data_r;
                tx_empty_r <= 1'b0;
            end else if (burst_done || !ctrl_r[`DTP_CTRL_BURST]) begin
                tx_empty_r <= 1'b1;
            end
            tx_flag_r <= burst_done | (tx_flag_r &
                !(rd_end && rd_rs_r == `DTP_RS_CTRL));
            rx_flag_r <= (dsf & !dsf_r) | (rx_flag_r &
                !(rd_end && rd_rs_r == `DTP_RS_CTRL));
        end
    end

    // Alert pull request by mode. Call-progress select wins over
    // interrupt mode; with neither the pin stays released.
    always @* begin
        if (both_pd) begin
            alert_pull = 1'b0;
        end else if (ctrl_r[`DTP_CTRL_CP_SEL]) begin
            alert_pull = !i_cp_limited & !i_rx_power_down;
        end else if (ctrl_r[`DTP_CTRL_IRQ_EN]) begin
            alert_pull = rx_flag_r | tx_flag_r | dsf;
        end else begin
            alert_pull = 1'b0;
        end
    end

    // Open-drain alert, tone control, filter select and oscillator.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_alert_or_tone_monitor <= 1'b0;
            o_alert_or_tone_monitor_oe <= 1'b0;
            o_tone_on <= 1'b0;
            o_tone_code <= 4'h0;
            o_tone_oe <= 1'b0;
            o_cp_filter_sel <= 1'b0;
            o_osc_enable <= 1'b0;
        end else begin
            o_alert_or_tone_monitor <= 1'b0;
            o_alert_or_tone_monitor_oe <= alert_pull;
            o_tone_code <= tx_data_r;
            // Tone runs during a burst, or freely when bursts are off.
            o_tone_on <= !i_tx_power_down & ctrl_r[`DTP_CTRL_TONE_EN] &
                (ctrl_r[`DTP_CTRL_BURST] ? (state_r == ST_TONE) : 1'b1);
            o_tone_oe <= !i_tx_power_down;
            o_cp_filter_sel <= ctrl_r[`DTP_CTRL_CP_SEL];
            // Crystal or external clock runs unless both halves sleep.
            o_osc_enable <= !both_pd;
        end
    end
endmodule
`default_nettype wire

// ---- dtp_defs.vh ----
// Purpose: Shared constants for the tone transceiver host port.
// Assumes: A 40 MHz core clock; all pins arrive synchronous to it.
// Notes: Register fields, reset values and timing figures live here.
//
// Function
// - Shared pin is direction or write strobe.
// - Register select line chooses the register.
// - Data lines float outside an active read.
// - Interrupt mode pulls alert low after burst.
// - Call-progress mode outputs rectangular input copy.
// - Early detect follows valid tone pair presence.
// - Steering high registers tone, updates latch.
// - Steering low frees device for new tone.
// - Guard drive follows early detect and steering.
// - Timebase from crystal or external clock.
// - Transmitter and receiver power down independently.
// - Burst mode times tone and pause exactly.
// - Software selects the call-progress filter.
// - Tone pairs map to fixed 4-bit codes.
// - Alert low while delayed steering flag active.
// - Transmit power down floats the tone output.
// - Both power downs stop oscillator, float pins.
`ifndef DTP_DEFS_VH
`define DTP_DEFS_VH

// Register select values.
`define DTP_RS_DATA 1'b0
`define DTP_RS_CTRL 1'b1

// Control register field positions and reset value.
`define DTP_CTRL_TONE_EN 0
`define DTP_CTRL_BURST 1
`define DTP_CTRL_IRQ_EN 2
`define DTP_CTRL_CP_SEL 3
`define DTP_CTRL_RST 4'h0

// Status register field positions.
`define DTP_STAT_IRQ 0
`define DTP_STAT_TX_EMPTY 1
`define DTP_STAT_RX_READY 2

// Clock rate in two units.
`define DTP_CLK_MHZ 40
`define DTP_CLK_KHZ 40000

// Burst tone and pause lengths in milliseconds.
`define DTP_BURST_MS 50
`define DTP_PAUSE_MS 50

// Output latch settle delay before the delayed steering flag rises.
`define DTP_SETTLE_NS 1000
`define DTP_SETTLE_CYC ((`DTP_SETTLE_NS * `DTP_CLK_MHZ + 999) / 1000)

`endif

// ---- dtp_tone_decode.v ----
// Purpose: Map a detected low/high tone group pair to its 4-bit code.
// Assumes: Indices count tones upward from the lowest of each group.
// Notes: Purely combinational lookup; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module dtp_tone_decode (
    input wire [1:0] i_low_idx, // Low group tone index.
    input wire [1:0] i_high_idx, // High group tone index.
    output reg [3:0] o_code // Encoded digit.
);
    // Lookup of the sixteen tone pairs.
    always @* begin
        case ({i_low_idx, i_high_idx})
            4'h0: o_code = 4'h1;
            4'h1: o_code = 4'h2;
            4'h2: o_code = 4'h3;
            4'h3: o_code = 4'hD;
            4'h4: o_code = 4'h4;
            4'h5: o_code = 4'h5;
            4'h6: o_code = 4'h6;
            4'h7: o_code = 4'hE;
            4'h8: o_code = 4'h7;
            4'h9: o_code = 4'h8;
            4'hA: o_code = 4'h9;
            4'hB: o_code = 4'hF;
            4'hC: o_code = 4'hB;
            4'hD: o_code = 4'hA;
            4'hE: o_code = 4'hC;
            default: o_code = 4'h0;
        endcase
    end
endmodule
`default_nettype wire

// ---- dtp_steer.v ----
// Purpose: Early detect, guard drive and tone registration logic.
// Assumes: Steering input is a digital comparison against the threshold.
// Notes: The output latch changes only when the delayed flag rises.
`timescale 1ns/1ps
`include "dtp_defs.vh"
`default_nettype none
module dtp_steer (
    input wire i_clk, // Core clock.
    input wire i_rst, // Asynchronous reset, active high.
    input wire i_tone_valid, // Detector sees a valid pair.
    input wire [3:0] i_code, // Code of the detected pair.
    input wire i_steering_pin, // Steering level above threshold.
    input wire i_rx_pd, // Receiver powered down.
    output reg o_early_tone_detect, // Early detect output.
    output reg o_guard_drive, // Guard drive level.
    output reg o_guard_drive_oe, // Guard drive enable.
    output reg [3:0] o_rx_code, // Receive output latch.
    output reg o_delayed_steer // Delayed steering flag.
);
    localparam integer SETTLE_M1 = `DTP_SETTLE_CYC - 1; // Full width.
    localparam [7:0] SETTLE_LAST = SETTLE_M1[7:0]; // Cut to the counter.
    reg armed_r; // Ready to register a new pair.
    reg settling_r; // Waiting for the latch to settle.
    reg [7:0] settle_cnt_r; // Settle countdown.
    reg [3:0] pend_code_r; // Code captured at registration.

    // Registration, settle delay and delayed flag sequencing.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_early_tone_detect <= 1'b0;
            o_guard_drive <= 1'b0;
            o_guard_drive_oe <= 1'b0;
            o_rx_code <= 4'h0;
            o_delayed_steer <= 1'b0;
            armed_r <= 1'b1;
            settling_r <= 1'b0;
            settle_cnt_r <= 8'h00;
            pend_code_r <= 4'h0;
        end else if (i_rx_pd) begin
            // Receiver asleep: early detect and delayed flag low, guard released, latch and guard value held.
            o_early_tone_detect <= 1'b0;
            o_guard_drive_oe <= 1'b0;
            o_delayed_steer <= 1'b0;
            settling_r <= 1'b0;
            armed_r <= 1'b1;
        end else begin
            o_early_tone_detect <= i_tone_valid;
            // Drive only when level and early detect agree.
            o_guard_drive <= o_early_tone_detect;
            o_guard_drive_oe <= (o_early_tone_detect == i_steering_pin);
            if (!i_steering_pin) begin
                armed_r <= 1'b1;
                settling_r <= 1'b0;
                o_delayed_steer <= 1'b0;
            end else if (armed_r) begin
                armed_r <= 1'b0;
                pend_code_r <= i_code;
                settling_r <= 1'b1;
                settle_cnt_r <= SETTLE_LAST;
            end else if (settling_r) begin
                if (settle_cnt_r == 8'h00) begin
                    settling_r <= 1'b0;
                    o_delayed_steer <= 1'b1;
                    o_rx_code <= pend_code_r;
                end else begin
                    settle_cnt_r <= settle_cnt_r - 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- dtp_host_port_checker.sv ----
// Purpose: Pin level timing checks for the tone transceiver host port.
// Assumes: Sees only the ports of dtp_host_port, one clock domain.
// Notes: Attached by the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module dtp_host_port_checker (
    input wire logic i_clk, // Core clock.
    input wire logic i_rst, // Reset, active high.
    input wire logic i_bus_style, // Bus style.
    input wire logic i_chip_sel_n, // Chip select, active low.
    input wire logic i_rw_or_wr_n, // Direction or write strobe.
    input wire logic i_data_strobe_in, // Data or read strobe.
    input wire logic i_rx_power_down, // Receiver down.
    input wire logic i_tx_power_down, // Transmitter down.
    input wire logic i_tone_valid, // Valid pair seen.
    input wire logic i_cp_limited, // Band signal.
    input wire logic i_steering_pin, // Steering level.
    input wire logic o_host_data_lines_oe, // Data drive enable.
    input wire logic o_early_tone_detect, // Early detect.
    input wire logic o_guard_drive, // Guard value.
    input wire logic o_guard_drive_oe, // Guard enable.
    input wire logic o_alert_or_tone_monitor, // Alert value.
    input wire logic o_alert_or_tone_monitor_oe, // Alert enable.
    input wire logic o_tone_oe, // Tone pin enable.
    input wire logic o_cp_filter_sel, // Filter select.
    input wire logic o_osc_enable // Oscillator enable.
);
    // A read is under way while selected with the read strobe of the style active.
    wire rd_act = !i_chip_sel_n && (i_bus_style ? !i_data_strobe_in
                                                : (i_data_strobe_in && i_rw_or_wr_n));
    // Both halves powered down.
    wire both_pd = i_rx_power_down && i_tx_power_down;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    float_idle_a: assert property (o_host_data_lines_oe |-> $past(rd_act))
        else $error("data lines driven outside a read");
    drive_read_a: assert property (!$past(i_rst) && $past(rd_act && !both_pd)
        |-> o_host_data_lines_oe)
        else $error("data lines not driven during a read");
    all_down_a: assert property (!$past(i_rst) && $past(both_pd) |-> !o_osc_enable &&
        !o_host_data_lines_oe && !o_tone_oe && !o_alert_or_tone_monitor_oe)
        else $error("pins not floated with both halves down");
    tx_down_a: assert property ($past(i_tx_power_down) |-> !o_tone_oe)
        else $error("tone pin enabled while transmitter down");
    tx_up_a: assert property (!$past(i_rst) && !$past(i_tx_power_down)
        |-> o_tone_oe && o_osc_enable)
        else $error("transmitter held down by receiver setting");
    early_follow_a: assert property (!$past(i_rst) && !$past(i_rx_power_down)
        |-> o_early_tone_detect == $past(i_tone_valid))
        else $error("early detect does not follow the detector");
    guard_rel_a: assert property (!$past(i_rst) && !$past(i_rx_power_down)
        |-> o_guard_drive == $past(o_early_tone_detect) &&
        o_guard_drive_oe == ($past(o_early_tone_detect) == $past(i_steering_pin)))
        else $error("guard drive wrong for early detect and steering");
    cp_track_a: assert property (o_cp_filter_sel && !$past(i_rst) && !$past(i_rx_power_down)
        |-> o_alert_or_tone_monitor_oe == !$past(i_cp_limited))
        else $error("alert pin does not follow the band signal");
    open_drain_a: assert property (o_alert_or_tone_monitor == 1'b0)
        else $error("alert pin driven high");
endmodule
bind dtp_host_port dtp_host_port_checker i_dtp_host_port_checker (.i_clk(i_clk), .i_rst(i_rst),
    .i_bus_style(i_bus_style), .i_chip_sel_n(i_chip_sel_n), .i_rw_or_wr_n(i_rw_or_wr_n),
    .i_data_strobe_in(i_data_strobe_in), .i_rx_power_down(i_rx_power_down),
    .i_tx_power_down(i_tx_power_down), .i_tone_valid(i_tone_valid), .i_cp_limited(i_cp_limited),
    .i_steering_pin(i_steering_pin), .o_host_data_lines_oe(o_host_data_lines_oe),
    .o_early_tone_detect(o_early_tone_detect), .o_guard_drive(o_guard_drive),
    .o_guard_drive_oe(o_guard_drive_oe), .o_alert_or_tone_monitor(o_alert_or_tone_monitor),
    .o_alert_or_tone_monitor_oe(o_alert_or_tone_monitor_oe), .o_tone_oe(o_tone_oe),
    .o_cp_filter_sel(o_cp_filter_sel), .o_osc_enable(o_osc_enable));
`default_nettype wire

// ---- dtp_host_mdl.sv ----
// Purpose: Host microcontroller model driving the four-bit port.
// Assumes: Signals change 2 ns after a rising edge.
// Notes: A floating data bus shows the inverse of its last level.
`timescale 1ns/1ps
`default_nettype none
module dtp_host_mdl (
    input wire logic i_clk, // Core clock.
    input wire logic i_style, // 0 strobe with direction, 1 separate strobes.
    input wire logic [3:0] i_dut_data, // Device read data.
    input wire logic i_dut_oe, // Device drives the bus.
    output logic o_cs_n, // Chip select, active low.
    output logic o_rw_wr_n, // Direction or write strobe.
    output logic o_strobe, // Data or read strobe.
    output logic o_rs, // Register select.
    output logic [3:0] o_bus // Resolved data bus.
);
    logic sel = 1'b0; // Access in progress.
    logic wr = 1'b0; // Access is a write.
    logic hoe = 1'b0; // Host drives the bus.
    logic [3:0] hd = 4'h0; // Host write data.
    logic [3:0] last = 4'h0; // Bus level one cycle ago.
    initial o_rs = 1'b0;
    // Select only inside an access, as the address qualify would give.
    assign o_cs_n = !sel;
    // Shared pin is direction in style 0 and write strobe in style 1.
    assign o_rw_wr_n = !wr;
    // Strobe moves only during an access.
    assign o_strobe = i_style ? !(sel && !wr) : sel;
    // Bus level from all drivers; nobody driving gives a changing pattern.
    assign o_bus = i_dut_oe ? i_dut_data : (hoe ? hd : ~last);
    // Remember the bus for the floating pattern.
    always @(posedge i_clk) begin
        last <= o_bus;
    end
    // One access; reads hold until the device answers or four edges pass.
    task automatic acc(input logic w, input logic rs, input logic [3:0] d,
                       output logic [3:0] q);
        int n;
        begin
            n = 0;
            @(posedge i_clk);
            #2;
            sel = 1'b1;
            wr = w;
            o_rs = rs;
            hd = d;
            hoe = w;
            @(posedge i_clk);
            #2;
            while (!w && i_dut_oe !== 1'b1 && n < 4) begin
                @(posedge i_clk);
                #2;
                n++;
            end
            q = o_bus;
            if (!w) begin
                @(posedge i_clk);
                #2;
            end
            sel = 1'b0;
            wr = 1'b0;
            hoe = 1'b0;
            @(posedge i_clk);
            #2;
        end
    endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for the tone transceiver host port.
// Assumes: Burst and pause shortened to 20 cycles each.
// Notes: Bus cycles come from the host model tasks.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int BURST_N = 20; // Shortened burst length.
    logic i_clk = 1'b0, i_rst = 1'b1, sty = 1'b0, rx_pd = 1'b0, tx_pd = 1'b0;
    logic tv = 1'b0, cpl = 1'b1, st = 1'b0;
    logic [1:0] lo = 2'h0, hi = 2'h0;
    logic [3:0] q;
    wire cs_n, rw, ds, rs, doe, early_tone_detect, gd, gdoe, al, aloe, ton, toe, cps, osc;
    wire [3:0] bus, dd, tcode;
    int err_count = 0, num_checks = 0, n;
    // Expected code for each low and high tone index pair.
    logic [3:0] codes [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6, 4'hE,
                               4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};
    // Core timebase at 40 MHz.
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    dtp_host_port #(.CNT_W(22), .BURST_CYC(BURST_N), .PAUSE_CYC(20)) i_dtp_host_port (
        .i_clk(i_clk), .i_rst(i_rst), .i_bus_style(sty), .i_chip_sel_n(cs_n),
        .i_rw_or_wr_n(rw), .i_data_strobe_in(ds), .i_reg_select_line(rs),
        .i_host_data_lines(bus), .o_host_data_lines(dd), .o_host_data_lines_oe(doe),
        .i_rx_power_down(rx_pd), .i_tx_power_down(tx_pd), .i_tone_valid(tv),
        .i_low_idx(lo), .i_high_idx(hi), .i_cp_limited(cpl), .i_steering_pin(st),
        .o_early_tone_detect(early_tone_detect), .o_guard_drive(gd), .o_guard_drive_oe(gdoe),
        .o_alert_or_tone_monitor(al), .o_alert_or_tone_monitor_oe(aloe), .o_tone_on(ton),
        .o_tone_code(tcode), .o_tone_oe(toe), .o_cp_filter_sel(cps), .o_osc_enable(osc));
    dtp_host_mdl i_dtp_host_mdl (.i_clk(i_clk), .i_style(sty), .i_dut_data(dd),
        .i_dut_oe(doe), .o_cs_n(cs_n), .o_rw_wr_n(rw), .o_strobe(ds), .o_rs(rs), .o_bus(bus));
    // Wait whole cycles, landing 2 ns after the edge.
    task automatic step(input int c);
        repeat (c) @(posedge i_clk);
        #2;
    endtask
    // Compare and count.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Register write and read through the host model.
    task automatic wr(input logic r, input logic [3:0] d);
        i_dtp_host_mdl.acc(1'b1, r, d, q);
    endtask
    task automatic rd(input logic r);
        i_dtp_host_mdl.acc(1'b0, r, 4'h0, q);
    endtask
    // Print counts and verdict, then stop.
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Cut a hang short.
    initial begin
        #(20000 * 25);
        err_count++;
        give_verdict();
    end
    // Main sequence.
    initial begin
        step(6);
        i_rst = 1'b0;
        step(2);
        chk(osc, 1);
        chk(toe, 1);
        chk(aloe, 0);
        $display("reset test done");
        wr(1'b1, 4'h8);
        step(1);
        chk(cps, 1);
        cpl = 1'b0;
        step(2);
        chk(aloe, 1);
        cpl = 1'b1;
        step(2);
        chk(aloe, 0);
        wr(1'b1, 4'h0);
        cpl = 1'b0;
        step(2);
        chk(aloe, 0);
        cpl = 1'b1;
        $display("call progress test done");
        wr(1'b1, 4'h4);
        for (int k = 0; k < 16; k++) begin
            lo = k[3:2];
            hi = k[1:0];
            tv = 1'b1;
            step(3);
            chk(early_tone_detect, 1);
            st = 1'b1;
            step(45);
            rd(1'b0);
            chk(q, codes[k]);
            chk(aloe, 1);
            rd(1'b1);
            chk(q & 4'h5, 4'h5);
            tv = 1'b0;
            st = 1'b0;
            step(3);
            chk(early_tone_detect, 0);
            chk(aloe, 0);
        end
        $display("steering test done");
        wr(1'b1, 4'h7);
        wr(1'b0, 4'h5);
        for (n = 0; n < 10 && ton !== 1'b1; n++) step(1);
        chk(tcode, 4'h5);
        for (n = 0; n < 100 && ton === 1'b1; n++) step(1);
        chk(n[7:0], 8'(BURST_N));
        for (n = 0; n < 60 && aloe !== 1'b1; n++) step(1);
        chk(aloe, 1);
        rd(1'b1);
        chk(q & 4'h1, 4'h1);
        step(2);
        chk(aloe, 0);
        $display("burst test done");
        tx_pd = 1'b1;
        step(2);
        chk(toe, 0);
        chk(osc, 1);
        rx_pd = 1'b1;
        step(2);
        chk(osc, 0);
        rd(1'b1);
        tx_pd = 1'b0;
        step(2);
        chk(toe, 1);
        chk(osc, 1);
        rx_pd = 1'b0;
        $display("power down test done");
        sty = 1'b1;
        step(2);
        wr(1'b1, 4'h8);
        step(1);
        chk(cps, 1);
        rd(1'b1);
        chk(q, 4'h2);
        wr(1'b1, 4'h0);
        step(1);
        chk(cps, 0);
        $display("strobe style test done");
        give_verdict();
    end
endmodule
`default_nettype wire
